// ===== hdl/bcd_stack_pkg.sv
// constants and types shared by the bcd stack arithmetic unit
package bcd_stack_pkg;

  // ------------------------------------------------------------
  // widths and sizes
  // ------------------------------------------------------------
  localparam int WORD_W      = 32;
  localparam int HALF_W      = 16;
  localparam int NIB_W       = 4;
  localparam int DIGITS_WORD = 8;
  localparam int STACK_DEPTH = 8;
  localparam int RUN_LEN_W   = 5;
  localparam int REG_ADDR_W  = 3;

  // ------------------------------------------------------------
  // bcd digit constants
  // ------------------------------------------------------------
  localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
  localparam logic [3:0]  BCD_ADJUST    = 4'h6;
  localparam logic [3:0]  NIB_ZERO      = 4'h0;
  localparam logic [3:0]  NIB_ONE       = 4'h1;
  localparam logic [15:0] HALF_ZERO     = 16'h0000;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  DIGITS_LAST   = 2'h3;
  localparam logic [1:0]  DIGIT_STEP    = 2'h1;
  localparam logic [16:0] RUN_ONE       = 17'h0_0001;
  localparam logic [15:0] RUN_ONE16     = 16'h0001;

  // ------------------------------------------------------------
  // operation codes and engine states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE          = 3'h0,
    OP_LOAD          = 3'h1,
    OP_MUL_BITRUN    = 3'h2,
    OP_DIV_BITRUN    = 3'h3,
    OP_ADD_STACK_TOP = 3'h4,
    OP_SUB_STACK_TOP = 3'h5,
    OP_MUL_STACK_TOP = 3'h6
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_MUL       = 4'b0010,
    ST_DIV_SHIFT = 4'b0100,
    ST_DIV_SUB   = 4'b1000
  } state_t;

  // ------------------------------------------------------------
  // register map and field positions
  // ------------------------------------------------------------
  localparam logic [2:0] REG_ACC        = 3'h0;
  localparam logic [2:0] REG_STACK_TOP  = 3'h1;
  localparam logic [2:0] REG_FLAGS      = 3'h2;
  localparam logic [2:0] REG_IRQ_STATUS = 3'h3;
  localparam logic [2:0] REG_IRQ_MASK   = 3'h4;

  localparam int FLAG_W      = 7;
  localparam int FLG_ZERO    = 0;
  localparam int FLG_NEG     = 1;
  localparam int FLG_INVALID = 2;
  localparam int FLG_CARRY16 = 3;
  localparam int FLG_CARRY32 = 4;
  localparam int FLG_BORROW16 = 5;
  localparam int FLG_BORROW32 = 6;

  localparam int EVT_W        = 4;
  localparam int EVT_DONE     = 0;
  localparam int EVT_INVALID  = 1;
  localparam int EVT_DIV_ZERO = 2;
  localparam int EVT_OVERFLOW = 3;

  localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
  localparam logic [EVT_W-1:0]  MASK_RESET  = 4'h0;

endpackage : bcd_stack_pkg

// ===== hdl/bcd_addsub32.sv
// eight-digit bcd adder and ten's complement subtractor
`timescale 1ns/1ps
module bcd_addsub32
  import bcd_stack_pkg::*;
(
  // operands
  input  wire logic [WORD_W-1:0] x,
  input  wire logic [WORD_W-1:0] y,
  input  wire logic              sub,
  // result
  output logic      [WORD_W-1:0] s,
  output logic                   c16,
  output logic                   c32,
  output logic                   bad
);

  logic [DIGITS_WORD:0]   cy;
  logic [DIGITS_WORD-1:0] bd;

  // subtraction adds the nines complement plus one
  assign cy[0] = sub;

  for (genvar i = 0; i < DIGITS_WORD; i++) begin : g_digit
    logic [3:0] xd;
    logic [3:0] yd;
    logic [3:0] ym;
    logic [4:0] raw;
    assign xd = x[NIB_W*i +: NIB_W];
    assign yd = y[NIB_W*i +: NIB_W];
    assign ym = sub ? 4'(BCD_MAX_DIGIT - yd) : yd;
    assign raw = {1'b0, xd} + {1'b0, ym} + {4'h0, cy[i]};
    assign cy[i+1] = raw > {1'b0, BCD_MAX_DIGIT};
    assign s[NIB_W*i +: NIB_W] = cy[i+1] ? 4'(raw[3:0] + BCD_ADJUST) : raw[3:0];
    assign bd[i] = (xd > BCD_MAX_DIGIT) | (yd > BCD_MAX_DIGIT);
  end

  // carry out of digit four is the 16-bit carry, of digit eight the 32-bit one
  assign c16 = cy[DIGITS_WORD/2];
  assign c32 = cy[DIGITS_WORD];
  assign bad = |bd;

endmodule : bcd_addsub32

// ===== hdl/bcd_stack_arith_unit.sv
// bcd accumulator with push-down stack, bit-run and stack arithmetic
//
// Contract
// - mul_bitrun multiplies accumulator by the masked bit-run value, product to accumulator (only the low four accumulator digits are multiplied)
// - div_bitrun puts quotient in accumulator and remainder in first stack level
// - add_stack_top adds accumulator and first stack level as 32-bit bcd
// - sub_stack_top subtracts first stack level from accumulator as 32-bit bcd
// - mul_stack_top multiplies four-digit stack top by four-digit accumulator
// - stack add, subtract and multiply pop the first level, others move up
// - a load pushes the old accumulator onto the stack first
// - zero flag set when the result accumulator is zero, cleared otherwise
// - negative flag follows the sign bit of the result accumulator
// - invalid-digit flag set when any operand nibble is not a bcd digit
// - add sets separate 16-bit and 32-bit carry flags
// - subtract sets separate 16-bit and 32-bit borrow flags
// - flags change only on operations that affect them
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module bcd_stack_arith_unit
  import bcd_stack_pkg::*;
(
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // operation request
  input  wire logic                   OP_VALID,
  input  wire op_t                    OP_CODE,
  input  wire logic [WORD_W-1:0]      LOAD_VALUE,
  input  wire logic [HALF_W-1:0]      RUN_BITS,
  input  wire logic [RUN_LEN_W-1:0]   RUN_LEN,
  // operation status
  output logic                        BUSY,
  output logic                        DONE,
  output logic      [WORD_W-1:0]      ACC,
  output logic      [WORD_W-1:0]      STACK_TOP,
  // status flags
  output logic                        ZERO_FLAG,
  output logic                        NEGATIVE_FLAG,
  output logic                        INVALID_DIGIT_FLAG,
  output logic                        CARRY16_FLAG,
  output logic                        CARRY32_FLAG,
  output logic                        BORROW16_FLAG,
  output logic                        BORROW32_FLAG,
  // register port
  input  wire logic [REG_ADDR_W-1:0]  REG_ADDR,
  input  wire logic [WORD_W-1:0]      REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [WORD_W-1:0]      REG_RDATA,
  // interrupt
  output logic                        IRQ
);

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    state_t                              st;
    op_t                                 op;
    logic [WORD_W-1:0]                   acc;
    logic [STACK_DEPTH-1:0][WORD_W-1:0]  stk;
    logic [FLAG_W-1:0]                   flg;
    logic [WORD_W-1:0]                   quo;
    logic [HALF_W-1:0]                   dv;
    logic [HALF_W-1:0]                   wb;
    logic [WORD_W-1:0]                   rem;
    logic [3:0]                          cnt;
    logic [1:0]                          left;
    logic                                inv;
    logic                                busy;
    logic                                done;
    logic [EVT_W-1:0]                    sts;
    logic [EVT_W-1:0]                    msk;
    logic [WORD_W-1:0]                   rdata;
    logic                                irq;
  } regs_t;

  regs_t q, d;

  // ------------------------------------------------------------
  // operand selection and the shared bcd adder
  // ------------------------------------------------------------
  logic [16:0]       run_pow;
  logic [HALF_W-1:0] run_val;
  logic              take, is16, engaged;
  logic [WORD_W-1:0] opnd;
  logic [WORD_W-1:0] ad_x, ad_y, ad_s;
  logic              ad_sub, ad_c16, ad_c32, ad_bad;
  // lengths above sixteen are clamped to the full sixteen-bit run
  assign run_pow = RUN_ONE << RUN_LEN;
  assign run_val = RUN_BITS & (run_pow[HALF_W-1:0] - RUN_ONE16);
  assign take    = OP_VALID && (q.st == ST_IDLE);
  assign is16    = (OP_CODE == OP_MUL_BITRUN) || (OP_CODE == OP_DIV_BITRUN)
                || (OP_CODE == OP_MUL_STACK_TOP);
  assign engaged = (q.st != ST_IDLE);
  assign opnd    = ((OP_CODE == OP_MUL_BITRUN) || (OP_CODE == OP_DIV_BITRUN))
                 ? {HALF_ZERO, run_val} : q.stk[0];

  // idle: operands of the new request; busy: running product or remainder
  assign ad_x   = engaged ? q.rem : (is16 ? {HALF_ZERO, q.acc[HALF_W-1:0]} : q.acc);
  assign ad_y   = engaged ? {HALF_ZERO, q.dv} : (is16 ? {HALF_ZERO, opnd[HALF_W-1:0]} : opnd);
  assign ad_sub = engaged ? (q.st == ST_DIV_SUB) : (OP_CODE == OP_SUB_STACK_TOP);

  bcd_addsub32 u_addsub (
    .x   (ad_x),
    .y   (ad_y),
    .sub (ad_sub),
    .s   (ad_s),
    .c16 (ad_c16),
    .c32 (ad_c32),
    .bad (ad_bad)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic              fin;
    logic [WORD_W-1:0] res;
    logic [EVT_W-1:0]  evt;
    fin = 1'b0;
    res = WORD_ZERO;
    evt = '0;
    d = q;
    d.done = 1'b0;
    d.rdata = WORD_ZERO;
    unique case (q.st)
      ST_IDLE: begin
        if (take) begin
          unique case (OP_CODE)
            OP_LOAD: begin
              d.stk = {q.stk[STACK_DEPTH-2:0], q.acc};
              d.acc = LOAD_VALUE;
              d.done = 1'b1;
              evt[EVT_DONE] = 1'b1;
            end
            OP_ADD_STACK_TOP, OP_SUB_STACK_TOP: begin
              d.acc = ad_s;
              d.stk = {WORD_ZERO, q.stk[STACK_DEPTH-1:1]};
              d.flg[FLG_ZERO] = (ad_s == WORD_ZERO);
              d.flg[FLG_NEG] = ad_s[WORD_W-1];
              d.flg[FLG_INVALID] = ad_bad;
              if (OP_CODE == OP_ADD_STACK_TOP) begin
                d.flg[FLG_CARRY16] = ad_c16;
                d.flg[FLG_CARRY32] = ad_c32;
                evt[EVT_OVERFLOW] = ad_c32;
              end else begin
                d.flg[FLG_BORROW16] = !ad_c16;
                d.flg[FLG_BORROW32] = !ad_c32;
                evt[EVT_OVERFLOW] = !ad_c32;
              end
              d.done = 1'b1;
              evt[EVT_DONE] = 1'b1;
              evt[EVT_INVALID] = ad_bad;
            end
            OP_MUL_BITRUN, OP_MUL_STACK_TOP: begin
              d.st = ST_MUL;
              d.op = OP_CODE;
              d.dv = q.acc[HALF_W-1:0];
              d.cnt = opnd[HALF_W-1 -: NIB_W];
              d.wb = {opnd[HALF_W-NIB_W-1:0], NIB_ZERO};
              d.left = DIGITS_LAST;
              d.rem = WORD_ZERO;
              d.inv = ad_bad;
            end
            OP_DIV_BITRUN: begin
              if (run_val == HALF_ZERO) begin
                // a zero divisor leaves accumulator, stack and flags alone
                d.done = 1'b1;
                evt[EVT_DONE] = 1'b1;
                evt[EVT_DIV_ZERO] = 1'b1;
              end else begin
                d.st = ST_DIV_SHIFT;
                d.op = OP_CODE;
                d.dv = run_val;
                d.wb = q.acc[HALF_W-1:0];
                d.quo = WORD_ZERO;
                d.left = DIGITS_LAST;
                d.rem = WORD_ZERO;
                d.inv = ad_bad;
              end
            end
            default: d.done = 1'b0;
          endcase
        end
      end
      ST_MUL: begin
        // one add of the multiplicand per unit of the current multiplier digit
        if (q.cnt != NIB_ZERO) begin
          d.rem = ad_s;
          d.cnt = q.cnt - NIB_ONE;
        end else if (q.left == 2'h0) begin
          fin = 1'b1;
          res = q.rem;
        end else begin
          d.rem = {q.rem[WORD_W-NIB_W-1:0], NIB_ZERO};
          d.cnt = q.wb[HALF_W-1 -: NIB_W];
          d.wb = {q.wb[HALF_W-NIB_W-1:0], NIB_ZERO};
          d.left = q.left - DIGIT_STEP;
        end
      end
      ST_DIV_SHIFT: begin
        d.rem = {q.rem[WORD_W-NIB_W-1:0], q.wb[HALF_W-1 -: NIB_W]};
        d.wb = {q.wb[HALF_W-NIB_W-1:0], NIB_ZERO};
        d.cnt = NIB_ZERO;
        d.st = ST_DIV_SUB;
      end
      ST_DIV_SUB: begin
        // no borrow means the divisor still fits; the cap at nine bounds non-bcd divisors
        if (ad_c32 && (q.cnt != BCD_MAX_DIGIT)) begin
          d.rem = ad_s;
          d.cnt = q.cnt + NIB_ONE;
        end else begin
          d.quo = {q.quo[WORD_W-NIB_W-1:0], q.cnt};
          if (q.left == 2'h0) begin
            fin = 1'b1;
            res = {q.quo[WORD_W-NIB_W-1:0], q.cnt};
          end else begin
            d.left = q.left - DIGIT_STEP;
            d.st = ST_DIV_SHIFT;
          end
        end
      end
    endcase
    // completion writes accumulator, stack and flags in one step
    if (fin) begin
      d.st = ST_IDLE;
      d.acc = res;
      d.flg[FLG_ZERO] = (res == WORD_ZERO);
      d.flg[FLG_NEG] = res[WORD_W-1];
      d.flg[FLG_INVALID] = q.inv;
      if (q.op == OP_MUL_STACK_TOP) d.stk = {WORD_ZERO, q.stk[STACK_DEPTH-1:1]};
      if (q.op == OP_DIV_BITRUN) d.stk[0] = q.rem;
      d.done = 1'b1;
      evt[EVT_DONE] = 1'b1;
      evt[EVT_INVALID] = q.inv;
    end
    d.busy = (d.st != ST_IDLE);
    // register port; a status read clears, a new event in the same cycle wins
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_ACC:        d.rdata = q.acc;
        REG_STACK_TOP:  d.rdata = q.stk[0];
        REG_FLAGS:      d.rdata = {{(WORD_W-FLAG_W){1'b0}}, q.flg};
        REG_IRQ_STATUS: d.rdata = {{(WORD_W-EVT_W){1'b0}}, q.sts};
        REG_IRQ_MASK:   d.rdata = {{(WORD_W-EVT_W){1'b0}}, q.msk};
        default:        d.rdata = WORD_ZERO;
      endcase
    end
    if (REG_RD && (REG_ADDR == REG_IRQ_STATUS)) begin
      d.sts = evt;
    end else begin
      d.sts = q.sts | evt;
    end
    if (REG_WR && (REG_ADDR == REG_IRQ_MASK)) begin
      d.msk = REG_WDATA[EVT_W-1:0];
    end
    d.irq = |(d.sts & d.msk);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.op <= OP_NONE;
      q.flg <= FLAGS_RESET;
      q.msk <= MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign BUSY               = q.busy;
  assign DONE               = q.done;
  assign ACC                = q.acc;
  assign STACK_TOP          = q.stk[0];
  assign ZERO_FLAG          = q.flg[FLG_ZERO];
  assign NEGATIVE_FLAG      = q.flg[FLG_NEG];
  assign INVALID_DIGIT_FLAG = q.flg[FLG_INVALID];
  assign CARRY16_FLAG       = q.flg[FLG_CARRY16];
  assign CARRY32_FLAG       = q.flg[FLG_CARRY32];
  assign BORROW16_FLAG      = q.flg[FLG_BORROW16];
  assign BORROW32_FLAG      = q.flg[FLG_BORROW32];
  assign REG_RDATA          = q.rdata;
  assign IRQ                = q.irq;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // worst case: four multiplier digits of fifteen adds, three shifts and the finish
  localparam int LONG_OP_MAX = 64;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_mul_start;
    take && ((OP_CODE == OP_MUL_BITRUN) || (OP_CODE == OP_MUL_STACK_TOP));
  endsequence
  sequence s_div_start;
    take && (OP_CODE == OP_DIV_BITRUN) && (run_val != HALF_ZERO);
  endsequence
  a_load_push: assert property (take && (OP_CODE == OP_LOAD) |=>
    (ACC == $past(LOAD_VALUE)) && (STACK_TOP == $past(q.acc)))
    else $error("load did not push the old accumulator");
  a_stack_pop: assert property (take && ((OP_CODE == OP_ADD_STACK_TOP)
    || (OP_CODE == OP_SUB_STACK_TOP)) |=> (STACK_TOP == $past(q.stk[1])))
    else $error("stack did not move up after stack operation");
  a_add_sum: assert property (take && (OP_CODE == OP_ADD_STACK_TOP) |=>
    DONE && (ACC == $past(ad_s)) && (CARRY32_FLAG == $past(ad_c32)))
    else $error("stack add result or carry wrong");
  a_sub_borrow: assert property (take && (OP_CODE == OP_SUB_STACK_TOP) |=>
    (BORROW16_FLAG != $past(ad_c16)) && (BORROW32_FLAG != $past(ad_c32)))
    else $error("stack subtract borrow flags wrong");
  a_carry16_flag: assert property (take && (OP_CODE == OP_ADD_STACK_TOP) |=>
    (CARRY16_FLAG == $past(ad_c16)) && $stable(BORROW32_FLAG))
    else $error("stack add 16-bit carry wrong");
  a_zero_flag: assert property (DONE && $past(q.st != ST_IDLE) |->
    (ZERO_FLAG == (ACC == WORD_ZERO)) && (NEGATIVE_FLAG == ACC[WORD_W-1]))
    else $error("zero or negative flag disagrees with accumulator");
  a_flag_hold: assert property (take && (OP_CODE == OP_LOAD) |=> $stable(q.flg))
    else $error("load changed status flags");
  a_mul_bound: assert property (s_mul_start |=> BUSY ##[1:LONG_OP_MAX] DONE)
    else $error("multiply did not complete in time");
  a_div_bound: assert property (s_div_start |=> BUSY ##[1:LONG_OP_MAX] DONE)
    else $error("divide did not complete in time");
  a_mul_pop: assert property ((q.st == ST_MUL) && (q.op == OP_MUL_STACK_TOP)
    && (q.cnt == NIB_ZERO) && (q.left == 2'h0) |=> (STACK_TOP == $past(q.stk[1])) && !BUSY)
    else $error("stack multiply did not pop on completion");
  a_invalid_flag: assert property (take && ((OP_CODE == OP_ADD_STACK_TOP)
    || (OP_CODE == OP_SUB_STACK_TOP)) |=> (INVALID_DIGIT_FLAG == $past(ad_bad)))
    else $error("invalid digit flag wrong");

endmodule : bcd_stack_arith_unit

// ===== testbench/seq_bitmem_model.sv
// sequencer and discrete bit memory model driving the operation port
`timescale 1ns/1ps
module seq_bitmem_model
  import bcd_stack_pkg::*;
(
  // clock and completion
  input  wire logic                 clk,
  input  wire logic                 done,
  // operation request
  output logic                      op_valid,
  output op_t                       op_code,
  output logic [WORD_W-1:0]         load_value,
  output logic [HALF_W-1:0]         run_bits,
  output logic [RUN_LEN_W-1:0]      run_len
);
  initial begin
    op_valid   = 1'b0;
    op_code    = OP_NONE;
    load_value = 32'h0000_0000;
    run_bits   = 16'h0000;
    run_len    = 5'h01;
  end

  // ------------------------------------------------------------
  // one request, then a bounded wait for completion
  // ------------------------------------------------------------
  task automatic issue(input op_t op, input logic [WORD_W-1:0] val,
                       input logic [HALF_W-1:0] bits, input logic [RUN_LEN_W-1:0] len);
    int n;
    n = 0;
    @(posedge clk);
    op_valid   <= 1'b1;
    op_code    <= op;
    load_value <= val;
    run_bits   <= bits;
    run_len    <= len;
    @(posedge clk);
    op_valid   <= 1'b0;
    op_code    <= OP_NONE;
    // released load_value and run_bits show their inverse, not the last value; run_len keeps its last value
    load_value <= ~val;
    run_bits   <= ~bits;
    #1;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : issue
endmodule : seq_bitmem_model

// ===== testbench/tb_bcd_stack_arith_unit.sv
// self-checking bench for the bcd stack arithmetic unit
`timescale 1ns/1ps
module tb_bcd_stack_arith_unit;
  import bcd_stack_pkg::*;
  logic CLK, RST, op_valid, busy, done, reg_wr, reg_rd, irq;
  op_t                op_code;
  logic [31:0]        load_value, acc, stack_top, reg_wdata, reg_rdata, d;
  logic [15:0]        run_bits;
  logic [4:0]         run_len;
  logic [6:0]         flg;
  logic [2:0]         reg_addr;
  int                 err_total, tests_run, cycles;

  initial begin
    CLK = 1'b0; RST = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 3'h0; reg_wdata = 32'h0; err_total = 0; tests_run = 0; cycles = 0;
  end
  always #10 CLK = ~CLK;

  seq_bitmem_model seq (.clk(CLK), .done(done), .op_valid(op_valid), .op_code(op_code),
    .load_value(load_value), .run_bits(run_bits), .run_len(run_len));

  bcd_stack_arith_unit uut (.CLK(CLK), .RST(RST), .OP_VALID(op_valid), .OP_CODE(op_code),
    .LOAD_VALUE(load_value), .RUN_BITS(run_bits), .RUN_LEN(run_len), .BUSY(busy),
    .DONE(done), .ACC(acc), .STACK_TOP(stack_top), .ZERO_FLAG(flg[0]),
    .NEGATIVE_FLAG(flg[1]), .INVALID_DIGIT_FLAG(flg[2]), .CARRY16_FLAG(flg[3]),
    .CARRY32_FLAG(flg[4]), .BORROW16_FLAG(flg[5]), .BORROW32_FLAG(flg[6]),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .IRQ(irq));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic state(input logic [31:0] a, input logic [31:0] t, input logic [6:0] f);
    chk(acc, a);
    chk(stack_top, t);
    chk({25'h0, flg}, {25'h0, f});
  endtask : state

  task automatic do_reset();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge CLK);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge CLK);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge CLK);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge CLK);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic ld(input logic [31:0] v);
    seq.issue(OP_LOAD, v, 16'h0000, 5'h01);
    chk({31'h0, done}, 32'h1);
  endtask : ld

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_add_sub();
    do_reset();
    state(32'h0, 32'h0, 7'h00);
    ld(32'h777); ld(32'h1); ld(32'h9999_9999);
    chk(stack_top, 32'h1);
    seq.issue(OP_ADD_STACK_TOP, 32'h0, 16'h0, 5'h01);
    state(32'h0, 32'h777, 7'h19);
    ld(32'h5); ld(32'h3);
    seq.issue(OP_SUB_STACK_TOP, 32'h0, 16'h0, 5'h01);
    state(32'h9999_9998, 32'h0, 7'h7a);
    rd(REG_FLAGS, d);
    chk(d, 32'h7a);
  endtask : t_add_sub

  task automatic t_mul_stack();
    do_reset();
    ld(32'h11); ld(32'h1234); ld(32'h9999);
    fork
      seq.issue(OP_MUL_STACK_TOP, 32'h0, 16'h0, 5'h01);
      begin
        repeat (3) @(posedge CLK);
        #1 chk({31'h0, busy}, 32'h1);
      end
    join
    state(32'h1233_8766, 32'h11, 7'h00);
    chk({31'h0, busy}, 32'h0);
  endtask : t_mul_stack

  task automatic t_bitrun();
    do_reset();
    ld(32'h33); ld(32'h25);
    seq.issue(OP_MUL_BITRUN, 32'h0, 16'hff07, 5'h04);
    state(32'h175, 32'h33, 7'h00);
    seq.issue(OP_MUL_BITRUN, 32'h0, 16'h0002, 5'h10);
    state(32'h350, 32'h33, 7'h00);
    seq.issue(OP_MUL_BITRUN, 32'h0, 16'hfff1, 5'h01);
    state(32'h350, 32'h33, 7'h00);
    ld(32'h100);
    seq.issue(OP_DIV_BITRUN, 32'h0, 16'h0007, 5'h03);
    state(32'h14, 32'h2, 7'h00);
    seq.issue(OP_MUL_BITRUN, 32'h0, 16'h0000, 5'h04);
    state(32'h0, 32'h2, 7'h01);
    seq.issue(OP_MUL_BITRUN, 32'h0, 16'h000a, 5'h04);
    chk({31'h0, flg[FLG_INVALID]}, 32'h1);
  endtask : t_bitrun

  task automatic t_irq();
    do_reset();
    rd(REG_IRQ_MASK, d);
    chk(d, 32'h0);
    wr(REG_IRQ_MASK, 32'h1);
    ld(32'h5);
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, irq}, 32'h1);
    rd(REG_IRQ_STATUS, d);
    chk(d, 32'h1);
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, irq}, 32'h0);
    wr(REG_IRQ_MASK, 32'h0);
    seq.issue(OP_DIV_BITRUN, 32'h0, 16'h0000, 5'h04);
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, irq}, 32'h0);
    rd(REG_IRQ_STATUS, d);
    chk(d, 32'h5);
    wr(3'h6, 32'hffff_ffff);
    wr(REG_ACC, 32'h0);
    rd(3'h7, d);
    chk(d, 32'h0);
    rd(REG_ACC, d);
    chk(d, 32'h5);
    rd(REG_IRQ_MASK, d);
    chk(d, 32'h0);
  endtask : t_irq

  initial begin
    t_add_sub();
    t_mul_stack();
    t_bitrun();
    t_irq();
    end_of_test();
  end
endmodule : tb_bcd_stack_arith_unit
